/* include/remap_cmd_pkg.sv */
// constants for the global command / status register block of the remapping unit
// assumes a 32-bit classic wishbone slave with byte addresses on adr_i
package remap_cmd_pkg;

    // register byte offsets
    localparam logic [11:0] GLOBAL_COMMAND_OFFSET = 12'h018;
    localparam logic [11:0] GLOBAL_STATUS_OFFSET = 12'h01C;
    localparam logic [11:0] ROOT_TABLE_ADDRESS_OFFSET = 12'h020;

    // field positions shared by command and status words
    localparam int TRANSLATION_ENABLE_BIT = 31;
    localparam int SET_ROOT_POINTER_BIT = 30;
    localparam int COMMAND_BYTE_LANE = 3;

    // reset values
    localparam logic [31:0] ROOT_TABLE_ADDRESS_RESET = 32'h0000_0000;
    localparam logic [31:0] ROOT_POINTER_RESET = 32'h0000_0000;
    localparam logic TRANSLATION_ENABLE_RESET = 1'b0;
    localparam logic ROOT_POINTER_STATUS_RESET = 1'b0;

    // what software keeps of the status word when composing a command
    localparam logic [31:0] ONE_SHOT_KEEP_MASK = 32'h96FF_FFFF;

    // answer for write-only and unmapped words
    localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;

endpackage

/* verilog/translation_enable_sequencer.sv */
// carries out one translation enable or disable request
// assumes drain_done and txn_boundary come from datapath logic on clk_sys
`timescale 1ns/1ps

module translation_enable_sequencer #(
    parameter bit DRAIN_SUPPORTED = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic request,
    input wire logic request_value,
    input wire logic drain_done,
    input wire logic txn_boundary,
    output logic enable,
    output logic drain_req,
    output logic busy
);

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_DRAIN,
        SEQ_SWITCH
    } seq_state_t;

    typedef struct packed {
        seq_state_t state;
        logic target;
        logic enable;
        logic drain_req;
    } seq_regs_t;

    seq_regs_t s;
    seq_regs_t next_s;

    always_comb
    begin
        next_s = s;
        unique case (s.state)
            SEQ_IDLE:
            begin
                // a write that repeats the present state is a no-op
                if (request && request_value != s.enable)
                begin
                    next_s.target = request_value;
                    if (request_value && DRAIN_SUPPORTED)
                    begin
                        next_s.state = SEQ_DRAIN;
                        next_s.drain_req = 1'b1;
                    end
                    else
                    begin
                        next_s.state = SEQ_SWITCH;
                    end
                end
            end
            SEQ_DRAIN:
            begin
                if (drain_done)
                begin
                    next_s.drain_req = 1'b0;
                    next_s.state = SEQ_SWITCH;
                end
            end
            SEQ_SWITCH:
            begin
                // switch only between transactions so none is half remapped
                if (txn_boundary)
                begin
                    next_s.enable = s.target;
                    next_s.state = SEQ_IDLE;
                end
            end
            default:
            begin
                // the fourth code of the state field is unused; fall back to idle
                next_s.state = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s.state <= SEQ_IDLE;
            s.target <= remap_cmd_pkg::TRANSLATION_ENABLE_RESET;
            s.enable <= remap_cmd_pkg::TRANSLATION_ENABLE_RESET;
            s.drain_req <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign enable = s.enable;
    assign drain_req = s.drain_req;
    assign busy = (s.state != SEQ_IDLE);

endmodule

/* verilog/remap_global_command_control.sv */
// global command, global status and root table address registers of the remapping unit
// assumes a classic wishbone master on clk_sys and datapath handshakes on the same clock
`timescale 1ns/1ps

module remap_global_command_control #(
    parameter int ADDR_WIDTH = 12,
    parameter bit DRAIN_SUPPORTED = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_WIDTH-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic drain_done,
    input wire logic txn_boundary,
    output logic drain_req,
    output logic remap_enable,
    output logic [31:0] root_pointer
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [31:0] root_table_address;
        logic [31:0] root_pointer;
        logic root_pointer_status;
        logic root_load_pending;
    } ctrl_regs_t;

    ctrl_regs_t s;
    ctrl_regs_t next_s;

    logic access;
    logic [ADDR_WIDTH-1:0] word_addr;
    logic cmd_hit;
    logic status_hit;
    logic root_addr_hit;
    logic root_addr_write;
    logic root_load_request;
    logic root_load_complete;
    logic te_request;
    logic te_busy;
    logic translation_enable_status;
    logic [31:0] status_word;
    logic [31:0] read_word;
    logic [31:0] root_address_written;

    // byte address with the lane bits dropped, compared against aligned offsets
    assign word_addr = {adr_i[ADDR_WIDTH-1:2], 2'b00};
    // ack blocks a second take of the same held strobe
    assign access = cyc_i & stb_i & ~s.ack;
    assign cmd_hit = access && we_i && sel_i[remap_cmd_pkg::COMMAND_BYTE_LANE]
        && word_addr == ADDR_WIDTH'(remap_cmd_pkg::GLOBAL_COMMAND_OFFSET);
    assign status_hit = (word_addr == ADDR_WIDTH'(remap_cmd_pkg::GLOBAL_STATUS_OFFSET));
    assign root_addr_hit = (word_addr == ADDR_WIDTH'(remap_cmd_pkg::ROOT_TABLE_ADDRESS_OFFSET));
    assign root_addr_write = access && we_i && root_addr_hit;

    // a pulse for this write only; nothing of it is kept for later writes
    assign te_request = cmd_hit && !te_busy;

    // a 0 in the pointer load field does nothing
    assign root_load_request = cmd_hit && dat_i[remap_cmd_pkg::SET_ROOT_POINTER_BIT];
    // pointer swap waits for a transaction boundary like the enable switch
    assign root_load_complete = s.root_load_pending && txn_boundary;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[remap_cmd_pkg::TRANSLATION_ENABLE_BIT] = translation_enable_status;
        status_word[remap_cmd_pkg::SET_ROOT_POINTER_BIT] = s.root_pointer_status;
    end

    always_comb
    begin
        // command word is write-only and reads as zero like any unmapped word
        read_word = remap_cmd_pkg::UNMAPPED_READ_VALUE;
        if (status_hit)
        begin
            read_word = status_word;
        end
        else if (root_addr_hit)
        begin
            read_word = s.root_table_address;
        end
    end

    // each byte lane of the root address takes new data only where its select is set
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            assign root_address_written[8*lane +: 8] = sel_i[lane] ? dat_i[8*lane +: 8]
                : s.root_table_address[8*lane +: 8];
        end
    endgenerate

    always_comb
    begin
        next_s = s;
        next_s.ack = 1'b0;

        // the working pointer sees the address as it stood before this cycle's write
        if (root_load_complete)
        begin
            next_s.root_pointer = s.root_table_address;
            next_s.root_pointer_status = 1'b1;
            next_s.root_load_pending = 1'b0;
        end

        // a new set wins over the completion of the previous one in the same cycle
        if (root_load_request)
        begin
            next_s.root_load_pending = 1'b1;
        end

        if (root_addr_write)
        begin
            next_s.root_table_address = root_address_written;
        end

        if (access)
        begin
            next_s.ack = 1'b1;
            // writes answer with the unmapped word; the master ignores it
            next_s.rdata = we_i ? remap_cmd_pkg::UNMAPPED_READ_VALUE : read_word;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s.ack <= 1'b0;
            s.rdata <= remap_cmd_pkg::UNMAPPED_READ_VALUE;
            s.root_table_address <= remap_cmd_pkg::ROOT_TABLE_ADDRESS_RESET;
            s.root_pointer <= remap_cmd_pkg::ROOT_POINTER_RESET;
            s.root_pointer_status <= remap_cmd_pkg::ROOT_POINTER_STATUS_RESET;
            s.root_load_pending <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // enable state lives in the sequencer flop; status mirrors it so it moves only on completion
    translation_enable_sequencer #(
        .DRAIN_SUPPORTED(DRAIN_SUPPORTED)
    ) u_te_seq (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .request(te_request),
        .request_value(dat_i[remap_cmd_pkg::TRANSLATION_ENABLE_BIT]),
        .drain_done(drain_done),
        .txn_boundary(txn_boundary),
        .enable(translation_enable_status),
        .drain_req(drain_req),
        .busy(te_busy)
    );

    assign remap_enable = translation_enable_status;
    assign dat_o = s.rdata;
    assign ack_o = s.ack;
    assign root_pointer = s.root_pointer;

endmodule

/* bench/remap_global_command_control_properties.sv */
// port assertions for the global command block
// assumes the bind at the foot of this file
`timescale 1ns/1ps
module remap_cmd_checker #(
    parameter int ADDR_WIDTH = 12,
    parameter bit DRAIN_SUPPORTED = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_WIDTH-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic drain_done,
    input wire logic txn_boundary,
    input wire logic drain_req,
    input wire logic remap_enable,
    input wire logic [31:0] root_pointer
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
// read data is captured at the taking edge, so compare with state one edge back
wire logic rd_ack = ack_o && !we_i;
a_cmd_reads_zero: assert property (rd_ack && adr_i == 12'h018 |-> dat_o == 32'h0)
    else $error("command word read not zero");
a_status_mirror: assert property (rd_ack && adr_i == 12'h01C |-> dat_o[31] == $past(remap_enable))
    else $error("status enable bit differs from state");
a_root_status: assert property (rd_ack && adr_i == 12'h01C && $past(root_pointer) != 32'h0 |-> dat_o[30])
    else $error("pointer loaded but status bit clear");
a_switch_boundary: assert property ($changed(remap_enable) |-> $past(txn_boundary))
    else $error("remapping switched off a boundary");
a_load_boundary: assert property ($changed(root_pointer) |-> $past(txn_boundary))
    else $error("pointer changed off a boundary");
a_drain_from_cmd: assert property ($rose(drain_req) |-> ack_o && we_i && dat_i[31])
    else $error("drain started without enable write");
a_drain_holds_off: assert property (drain_req && !drain_done |=> !remap_enable)
    else $error("enabled before drain done");
a_no_drain_on: assert property (remap_enable |-> !drain_req)
    else $error("drain while enabled");
endmodule
bind remap_global_command_control remap_cmd_checker #(
    .ADDR_WIDTH(ADDR_WIDTH),
    .DRAIN_SUPPORTED(DRAIN_SUPPORTED)
) chk (.*);

/* bench/remap_global_command_control_tb.sv */
// self-checking bench for the global command block
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module remap_global_command_control_tb;
logic clk_sys = '0, rst_n = '0, cyc_i = '0, stb_i = '0, we_i = '0, drain_done = '0, txn_boundary = '0;
logic [11:0] adr_i = '0;
logic [31:0] dat_i = '0, rd, ra, v;
logic [3:0] sel_i = '0, s;
wire logic [31:0] dat_o, root_pointer;
wire logic ack_o, drain_req, remap_enable;
int mismatches = 0, comparisons = 0, cycles = 0;
remap_global_command_control uut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .dat_i(dat_i),
    .sel_i(sel_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .drain_done(drain_done),
    .txn_boundary(txn_boundary),
    .drain_req(drain_req),
    .remap_enable(remap_enable),
    .root_pointer(root_pointer)
);
always #2 clk_sys = ~clk_sys;
task automatic give_verdict;
    if (mismatches == 0 && comparisons > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
always @(posedge clk_sys)
begin
    cycles++;
    if (cycles == 3000)
    begin
        mismatches++;
        give_verdict();
    end
end
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
        mismatches++;
        $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
endtask
// ack and read data are sampled before this edge's updates land
task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] e);
    @(posedge clk_sys);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= e;
    do @(posedge clk_sys); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
endtask
task automatic poll(input logic [31:0] exp);
    wb(1'b0, 12'h01C, '0, 4'hF);
    repeat (20)
        if (rd !== exp)
            wb(1'b0, 12'h01C, '0, 4'hF);
    chk(rd, exp);
endtask
function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] e);
    for (int i = 0; i < 4; i++)
        if (e[i])
            o[8*i+:8] = n[8*i+:8];
    return o;
endfunction
initial
begin
    void'($urandom(67044));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    poll(32'h0);
    wb(1'b0, 12'h018, '0, 4'hF);
    chk(rd, 32'h0);
    ra = '0;
    for (int i = 0; i < 6; i++)
    begin
        v = $urandom;
        s = 4'($urandom);
        wb(1'b1, 12'h020, v, s);
        ra = merge(ra, v, s);
        wb(1'b0, 12'h020, '0, 4'hF);
        chk(rd, ra);
    end
    txn_boundary <= 1'b1;
    wb(1'b1, 12'h018, 32'h0, 4'hF);
    repeat (4) @(posedge clk_sys);
    chk(root_pointer, 32'h0);
    txn_boundary <= 1'b0;
    wb(1'b1, 12'h018, 32'h4000_0000, 4'hF);
    repeat (4) @(posedge clk_sys);
    chk(root_pointer, 32'h0);
    txn_boundary <= 1'b1;
    poll(32'h4000_0000);
    chk(root_pointer, ra);
    txn_boundary <= 1'b0;
    wb(1'b1, 12'h018, (rd & 32'h96FF_FFFF) | 32'h8000_0000, 4'hF);
    repeat (4) @(posedge clk_sys);
    chk(32'(drain_req), 32'h1);
    drain_done <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(32'(remap_enable), 32'h0);
    poll(32'h4000_0000);
    txn_boundary <= 1'b1;
    poll(32'hC000_0000);
    chk(32'(remap_enable), 32'h1);
    wb(1'b1, 12'h020, ~ra, 4'hF);
    wb(1'b1, 12'h018, 32'h8000_0000, 4'hF);
    wb(1'b1, 12'h018, 32'h0, 4'h7);
    repeat (4) @(posedge clk_sys);
    chk(root_pointer, ra);
    chk(32'(remap_enable), 32'h1);
    // live pointer change; the copy at the new address is taken to translate identically
    wb(1'b1, 12'h018, 32'hC000_0000, 4'hF);
    poll(32'hC000_0000);
    chk(root_pointer, ~ra);
    drain_done <= 1'b0;
    wb(1'b1, 12'h018, 32'h0, 4'hF);
    poll(32'h4000_0000);
    chk(32'(drain_req), 32'h0);
    give_verdict();
end
endmodule
